//--- sram_host_pkg.sv
package sram_host_pkg;
    // Array geometry
    localparam int ADDR_WIDTH = 13;
    localparam int DATA_WIDTH = 8;
    // Clock rate
    localparam int CLK_PERIOD_NS = 20;
    // Device timing figures in ns
    localparam int ADDRESS_ACCESS_TIME_NS = 70;
    localparam int OUTPUT_ENABLE_ACCESS_NS = 35;
    localparam int OUTPUT_HOLD_TIME_NS = 10;
    localparam int WRITE_RELEASE_TIME_NS = 25;
    localparam int ADDR_TO_WRITE_END_NS = 60;
    localparam int WRITE_DATA_SETUP_NS = 30;
    localparam int WRITE_DATA_HOLD_NS = 5;
    localparam int WRITE_PULSE_NS = 50;
    localparam int CHIP_PULSE_NS = 55;
    localparam int ADDR_HOLD_NS = 0;
    // Power recovery delay; plain default, figure not printed here
    localparam int POWER_RECOVERY_DELAY_US = 200;
    // Least times round up to whole cycles, at least one
    localparam int READ_CYCLES = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES_RAW =
        (ADDR_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYCLES =
        (CHIP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW > WRITE_PULSE_CYCLES)
        ? WRITE_CYCLES_RAW : WRITE_PULSE_CYCLES;
    localparam int HOLD_CYCLES = 1;
    localparam int RECOVERY_CYCLES = POWER_RECOVERY_DELAY_US * 1000
        / CLK_PERIOD_NS;
    localparam int COUNT_WIDTH = 16;
    typedef enum logic [2:0]
    {
        SEQ_IDLE  = 3'b000,
        SEQ_READ  = 3'b001,
        SEQ_WRITE = 3'b010,
        SEQ_HOLD  = 3'b011,
        SEQ_FAIL  = 3'b100,
        SEQ_RECOV = 3'b101
    } state_t;
endpackage

//--- cycle_timer.sv
`timescale 1ns/10ps
// Down counter marking the end of a timed phase
module cycle_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load wins over counting; done is high while the count sits at zero
    always_comb
    begin
        if (load)
            next_count = load_value;
        else if (count != '0)
            next_count = count - WIDTH'(1);
        else
            next_count = count;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            count <= '0;
        else
            count <= next_count;
    end

    assign done = (count == '0);
endmodule

//--- sram_host.sv
`timescale 1ns/10ps
module sram_host #(
    parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYCLES
) (
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst,
    input  wire logic                                  req_valid,
    input  wire logic                                  req_write,
    input  wire logic [sram_host_pkg::ADDR_WIDTH-1:0]  req_addr,
    input  wire logic [sram_host_pkg::DATA_WIDTH-1:0]  req_wdata,
    input  wire logic                                  power_good,
    output logic                                       req_ready,
    output logic                                       rsp_valid,
    output logic [sram_host_pkg::DATA_WIDTH-1:0]       rsp_rdata,
    output logic                                       power_fail,
    output logic [sram_host_pkg::ADDR_WIDTH-1:0]       byte_address,
    output logic                                       chip_enable_n,
    output logic                                       output_enable_n,
    output logic                                       write_enable_n,
    input  wire logic [sram_host_pkg::DATA_WIDTH-1:0]  data_lines_in,
    output logic [sram_host_pkg::DATA_WIDTH-1:0]       data_lines_out,
    output logic                                       data_lines_oe
);
    localparam int CW = sram_host_pkg::COUNT_WIDTH;
    localparam int TW = 24;

    sram_host_pkg::state_t state;
    sram_host_pkg::state_t next_state;
    logic [CW-1:0]  count;
    logic [CW-1:0]  next_count;
    logic           timer_load;
    logic [TW-1:0]  timer_value;
    logic           recov_done;

    logic                                  next_req_ready;
    logic                                  next_rsp_valid;
    logic [sram_host_pkg::DATA_WIDTH-1:0]  next_rsp_rdata;
    logic [sram_host_pkg::ADDR_WIDTH-1:0]  next_byte_address;
    logic                                  next_chip_enable_n;
    logic                                  next_output_enable_n;
    logic                                  next_write_enable_n;
    logic [sram_host_pkg::DATA_WIDTH-1:0]  next_data_lines_out;
    logic                                  next_data_lines_oe;
    logic                                  next_power_fail;

    // Long recovery wait lives in its own timer so the main count stays small
    cycle_timer #(
        .WIDTH      (TW)
    ) cycle_timer_i (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (recov_done)
    );

    // Cycle sequencer: all pin changes are decided here
    always_comb
    begin
        next_state = state;
        next_count = count;
        timer_load = 1'b0;
        timer_value = TW'(RECOVERY_CYCLES);
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_byte_address = byte_address;
        next_chip_enable_n = chip_enable_n;
        next_output_enable_n = output_enable_n;
        next_write_enable_n = write_enable_n;
        next_data_lines_out = data_lines_out;
        next_data_lines_oe = data_lines_oe;
        case (state)
            sram_host_pkg::SEQ_IDLE:
            begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready)
                begin
                    next_req_ready = 1'b0;
                    // Address set in the same cycle as the strobes fall
                    next_byte_address = req_addr;
                    next_chip_enable_n = 1'b0;
                    if (req_write)
                    begin
                        // Both strobes fall together; outputs stay off
                        next_write_enable_n = 1'b0;
                        next_output_enable_n = 1'b1;
                        next_data_lines_out = req_wdata;
                        next_data_lines_oe = 1'b1; // Data well ahead
                        next_count = CW'(sram_host_pkg::WRITE_CYCLES);
                        next_state = sram_host_pkg::SEQ_WRITE;
                    end
                    else
                    begin
                        // Read: write enable high, chip enable low
                        next_output_enable_n = 1'b0;
                        next_data_lines_oe = 1'b0;
                        next_count = CW'(sram_host_pkg::READ_CYCLES);
                        next_state = sram_host_pkg::SEQ_READ;
                    end
                end
            end
            sram_host_pkg::SEQ_READ:
            begin
                // Sample only after the full access time, never the
                // undefined data of an early enable
                if (count > CW'(1))
                    next_count = count - CW'(1);
                else
                begin
                    next_rsp_rdata = data_lines_in;
                    next_rsp_valid = 1'b1;
                    next_chip_enable_n = 1'b1; // Floats the device
                    next_output_enable_n = 1'b1;
                    next_count = CW'(sram_host_pkg::HOLD_CYCLES);
                    next_state = sram_host_pkg::SEQ_HOLD;
                end
            end
            sram_host_pkg::SEQ_WRITE:
            begin
                // Pulse covers 50/55 ns and address 60 ns
                if (count > CW'(1))
                    next_count = count - CW'(1);
                else
                begin
                    // Both strobes rise together; data and address held
                    // one more cycle past the end
                    next_write_enable_n = 1'b1;
                    next_chip_enable_n = 1'b1;
                    next_count = CW'(sram_host_pkg::HOLD_CYCLES);
                    next_state = sram_host_pkg::SEQ_HOLD;
                end
            end
            sram_host_pkg::SEQ_HOLD:
            begin
                // Strobes stay high before the next access
                if (count > CW'(1))
                    next_count = count - CW'(1);
                else
                begin
                    next_data_lines_oe = 1'b0;
                    next_state = sram_host_pkg::SEQ_IDLE;
                end
            end
            sram_host_pkg::SEQ_FAIL:
            begin
                // Wait for the supply; device ignores us meanwhile
                if (power_good)
                begin
                    timer_load = 1'b1;
                    next_state = sram_host_pkg::SEQ_RECOV;
                end
            end
            sram_host_pkg::SEQ_RECOV:
            begin
                // No access until recovery delay has passed
                if (recov_done)
                    next_state = sram_host_pkg::SEQ_IDLE;
            end
            default:
            begin
                next_state = sram_host_pkg::SEQ_IDLE;
            end
        endcase
        // Supply loss aborts anything; a cut write loses one byte at most,
        // so the strobes go high at once
        if (!power_good)
        begin
            next_state = sram_host_pkg::SEQ_FAIL;
            next_req_ready = 1'b0;
            next_rsp_valid = 1'b0;
            next_chip_enable_n = 1'b1;
            next_write_enable_n = 1'b1;
            next_output_enable_n = 1'b1;
            next_data_lines_oe = 1'b0;
        end
        // Flag also covers the recovery wait, so requests hold off
        next_power_fail = (next_state == sram_host_pkg::SEQ_FAIL)
            || (next_state == sram_host_pkg::SEQ_RECOV);
    end

    // Registers; strobes idle high, supply assumed bad until seen good
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= sram_host_pkg::SEQ_FAIL;
            count <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            power_fail <= 1'b1;
            byte_address <= '0;
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            data_lines_out <= '0;
            data_lines_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            power_fail <= next_power_fail;
            byte_address <= next_byte_address;
            chip_enable_n <= next_chip_enable_n;
            output_enable_n <= next_output_enable_n;
            write_enable_n <= next_write_enable_n;
            data_lines_out <= next_data_lines_out;
            data_lines_oe <= next_data_lines_oe;
        end
    end
endmodule

//--- sram_host_checker.sv
`timescale 1ns/10ps
// Pin-side timing duties of the host toward the RAM
module sram_host_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        power_good,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        power_fail,
    input wire logic [12:0] byte_address,
    input wire logic        chip_enable_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic [7:0]  data_lines_out,
    input wire logic        data_lines_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Address frozen while both write strobes stay low
    a_addr_held_write: assert property (
        !chip_enable_n && !write_enable_n && $past(!write_enable_n)
        |-> $stable(byte_address)) else $error("address moved in write");
    // Three cycles of low strobe give 60 ns of valid address
    a_addr_setup_end: assert property (
        $rose(write_enable_n) |-> $past(!write_enable_n, 3))
        else $error("write ended too soon after address");
    // Strobe back high and address kept across the rising edge
    a_gap_after_end: assert property (
        $rose(chip_enable_n) && $past(power_good)
        |-> $stable(byte_address) ##1 chip_enable_n)
        else $error("no idle gap or address hold after access");
    // Abort on power loss drops the data early, so it is excluded
    a_data_window: assert property (
        $rose(write_enable_n) && $past(power_good) |-> data_lines_oe
        && $past(data_lines_oe, 2) && $stable(data_lines_out)
        && $past(data_lines_out, 2) == data_lines_out)
        else $error("write data setup or hold short");
    a_we_width: assert property (
        $fell(write_enable_n) |-> !write_enable_n [*3])
        else $error("write strobe pulse too short");
    a_ce_width: assert property (
        $fell(chip_enable_n) && !write_enable_n |-> !chip_enable_n [*3])
        else $error("chip enable write pulse too short");
    a_oe_off_write: assert property (
        !write_enable_n || data_lines_oe |-> output_enable_n)
        else $error("output enable low while host writes");
    a_fail_quiet: assert property (
        !power_good |-> ##2 chip_enable_n && write_enable_n
        && !data_lines_oe && power_fail && !req_ready)
        else $error("pins not quiet after power loss");
    c_write_end: cover property ($rose(write_enable_n));
    c_read_done: cover property (rsp_valid);
    c_power_loss: cover property ($rose(power_fail));
endmodule

bind sram_host sram_host_checker sram_host_checker_i (.ref_clk, .rst,
    .power_good, .req_ready, .rsp_valid, .power_fail, .byte_address,
    .chip_enable_n, .output_enable_n, .write_enable_n, .data_lines_out,
    .data_lines_oe);

//--- sram_device_model.sv
`timescale 1ns/10ps
// Behavioural battery-backed byte RAM facing the host pins
module sram_device_model #(
    parameter real REC_NS = 160.0
) (
    input  wire logic [12:0] byte_address,
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        supply_ok,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out
);
    logic [7:0] mem [8192];
    logic [7:0] last = 8'h00;
    logic       wr_ok = 1'b0;
    realtime    t_a = 0, t_e = 0, t_g = 0, t_up = 0;
    wire        wr = !chip_enable_n && !write_enable_n;
    // Time stamps for the access and recovery windows
    always @(byte_address) t_a = $realtime;
    always @(negedge chip_enable_n) t_e = $realtime;
    always @(negedge output_enable_n) t_g = $realtime;
    always @(posedge supply_ok) t_up = $realtime;
    // Store at the earlier rising strobe; a dying supply spoils one byte
    always @(posedge wr) wr_ok = supply_ok && $realtime >= t_up + REC_NS;
    always @(negedge wr)
        if (wr_ok && supply_ok)
            mem[byte_address] = dq_in;
        else if (wr_ok)
            mem[byte_address] = mem[byte_address] ^ 8'h5a;
    // Lines polled each ns; released lines show the inverse of the last
    always #1
    begin
        if (!supply_ok || $realtime < t_up + REC_NS || chip_enable_n
            || output_enable_n || !write_enable_n)
            dq_out = ~last;
        else if ($realtime < t_a + 10.0)
            dq_out = last;
        else if ($realtime >= t_a + 70.0 && $realtime >= t_e + 70.0
                 && $realtime >= t_g + 35.0)
        begin
            dq_out = mem[byte_address];
            last = dq_out;
        end
        else
            dq_out = ~mem[byte_address];
    end
endmodule

//--- test_sram_host.sv
`timescale 1ns/10ps
// Host controller against the behavioural RAM
module test_sram_host;
    localparam int REC = 8;
    logic        ref_clk = 1'b0, rst = 1'b1, power_good = 1'b1;
    logic        req_valid = 1'b0, req_write = 1'b0;
    logic [12:0] req_addr = 13'h0000, a, byte_address;
    logic [7:0]  req_wdata = 8'h00, d, rsp_rdata, dev_dq;
    logic [7:0]  data_lines_out, data_lines_in, shadow [8192], exp_q [$];
    logic        req_ready, rsp_valid, power_fail, chip_enable_n;
    logic        output_enable_n, write_enable_n, data_lines_oe;
    int          n_fail = 0, checks = 0, n;
    always #10 ref_clk = ~ref_clk;
    // Shared data wire: host wins while it drives
    assign data_lines_in = data_lines_oe ? data_lines_out : dev_dq;
    sram_host #(.RECOVERY_CYCLES(REC)) sram_host_i (.ref_clk, .rst,
        .req_valid, .req_write, .req_addr, .req_wdata, .power_good,
        .req_ready, .rsp_valid, .rsp_rdata, .power_fail, .byte_address,
        .chip_enable_n, .output_enable_n, .write_enable_n, .data_lines_in,
        .data_lines_out, .data_lines_oe);
    sram_device_model #(.REC_NS(REC * 20.0)) sram_device_model_i (
        .byte_address, .chip_enable_n, .output_enable_n, .write_enable_n,
        .supply_ok(power_good), .dq_in(data_lines_in), .dq_out(dev_dq));
    task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
        checks++;
        if (seen !== expv)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Valid stays up on return; each call drives it high again for its own request
    task automatic xfer(input logic w, input logic [12:0] ad,
                        input logic [7:0] wd);
        int k;
        k = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_wdata <= wd;
        if (w)
            shadow[ad] = wd;
        else
            exp_q.push_back(shadow[ad]);
        while (req_ready !== 1'b1 && k < 60)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 60)
            n_fail++;
        @(negedge ref_clk);
    endtask
    task automatic drain(input string name);
        int k;
        req_valid <= 1'b0;
        for (k = 0; k < 60 && exp_q.size() != 0; k++)
            @(negedge ref_clk);
        chk(8'(exp_q.size()), 8'h00);
        $display("test %s done", name);
        // One idle edge, so the next request is not driven in this step
        @(negedge ref_clk);
    endtask
    // Each read result is matched with the oldest note
    always @(negedge ref_clk)
        if (rsp_valid === 1'b1)
        begin
            // A response with no note behind it fails by itself
            if (exp_q.size() == 0)
                chk(8'h01, 8'h00);
            else
                chk(rsp_rdata, exp_q.pop_front());
        end
    initial
    begin
        #100000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(76809));
        repeat (5) @(negedge ref_clk);
        chk({5'h00, req_ready, power_fail, chip_enable_n}, 8'h03);
        rst <= 1'b0;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++)
            @(negedge ref_clk);
        chk(8'(n > REC), 8'h01);
        drain("reset");
        xfer(1'b1, 13'h0000, 8'ha5);
        xfer(1'b1, 13'h1fff, 8'h5a);
        xfer(1'b0, 13'h0000, 8'h00);
        xfer(1'b0, 13'h1fff, 8'h00);
        // Neighbouring bytes written and read back to back
        repeat (8)
        begin
            a = 13'($urandom);
            d = 8'($urandom);
            xfer(1'b1, a, d);
            xfer(1'b1, a + 13'h0001, ~d);
            xfer(1'b0, a, 8'h00);
            xfer(1'b0, a + 13'h0001, 8'h00);
        end
        drain("readwrite");
        // Supply lost in mid-write; the neighbour must survive
        xfer(1'b1, 13'h0abc, 8'h3c);
        xfer(1'b1, 13'h0abd, 8'hc3);
        req_valid <= 1'b0;
        repeat (2) @(negedge ref_clk);
        power_good <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({3'h0, req_ready, power_fail, chip_enable_n, write_enable_n,
             data_lines_oe}, 8'h0e);
        power_good <= 1'b1;
        @(negedge ref_clk);
        xfer(1'b0, 13'h0abc, 8'h00);
        drain("powerfail");
        wrap_up();
    end
endmodule
